//--- pkg/exc_entry_pkg.sv
`default_nettype none
package exc_entry_pkg;

  // machine state word bit positions (big-endian numbering, bit 0 = msb)
  localparam int MSW_USER_BIT    = 31 - 17;
  localparam int MSW_ME_BIT      = 31 - 19;
  localparam int MSW_IBO_BIT     = 31 - 15;
  localparam int MSW_VBS_BIT     = 31 - 25;
  localparam int MSW_RI_BIT      = 31 - 30;
  localparam int MSW_BO_BIT      = 31 - 31;

  // exception vector offsets
  localparam logic [31:0] VEC_EMUL   = 32'h0000_1000;
  localparam logic [31:0] VEC_DBKPT  = 32'h0000_1C00;
  localparam logic [31:0] VEC_IBKPT  = 32'h0000_1D00;
  localparam logic [31:0] VEC_XBKPT  = 32'h0000_1E00;
  // vector base choices and instruction length in bytes
  localparam logic [31:0] BASE_LOW   = 32'h0000_0000;
  localparam logic [31:0] BASE_HIGH  = 32'hFFF0_0000;
  localparam logic [31:0] INSN_BYTES = 32'h0000_0004;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_SAVE_PC = 8'h08;
  localparam logic [7:0] OFS_SAVE_ST = 8'h0C;
  localparam logic [7:0] OFS_BKPT_AD = 8'h10;
  localparam logic [7:0] OFS_FSTAT   = 8'h14;
  localparam logic [7:0] OFS_FTARGET = 8'h18;
  localparam logic [7:0] OFS_FAULT_A = 8'h1C;
  localparam logic [7:0] OFS_FAULT_C = 8'h20;

  // reset values
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [1:0]  RST_CTRL   = 2'h0;

  // float status field positions
  localparam int FST_STICKY_BIT = 25;
  localparam int FST_CLASS_LSB  = 12;

  typedef enum {EXC_NONE, EXC_EMUL, EXC_DBKPT, EXC_IBKPT, EXC_XBKPT} exc_kind_t;

  // one retiring instruction as presented by the sequencer
  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
    logic        unimpl;
    logic        cache_seg_tlb;
    logic        spr_access;
    logic        spr_internal;
    logic        spr_unimpl;
    logic        spr_priv_msb;
    logic        dbkpt_match;
    logic [31:0] data_ea;
    logic        ibkpt_match;
  } retire_t;

  // rounding outcome from the float unit
  typedef struct packed {
    logic        valid;
    logic        differs;
    logic        overflow;
    logic        ovf_enable;
    logic [63:0] result;
    logic [4:0]  class_sign;
  } fround_t;

endpackage : exc_entry_pkg
`default_nettype wire

//--- src/exc_entry.sv
// Function
// - inexact when rounded differs from exact
// - inexact on overflow with overflow disabled
// - inexact: sticky, target result, class field
// - unimplemented instruction traps to emulation
// - cache, segment, tlb instructions trap
// - unimplemented internal spr always emulates
// - external spr emulates if unprivileged field/supervisor
// - save pc of causing instruction
// - data breakpoint saves following pc
// - saved state: high half cleared, low half copied
// - saved state undefined after port reset
// - keep base/check, copy byte order, clear
// - vectors 1000, 1C00, 1D00 from base
// - load/store comparator match gives data breakpoint
// - fetch comparator match gives instruction breakpoint
// - breakpoints masked by recoverable flag optionally
// - unmasked hit without recoverable: non-restartable
// - data breakpoint leaves fault registers alone
// - data breakpoint captures data address
// - development port raises external breakpoint request
// - external breakpoint blocked while not recoverable
// - external breakpoint vectors to 1E00
// - exception taken at retirement, flush younger
`timescale 1ns/1ps
`default_nettype none
module exc_entry (
  // clock and reset
  input  wire logic                       SYS_CLK_I,
  input  wire logic                       RST_I,
  // apb slave
  input  wire logic                       PSEL_I,
  input  wire logic                       PENABLE_I,
  input  wire logic                       PWRITE_I,
  input  wire logic [7:0]                 PADDR_I,
  input  wire logic [31:0]                PWDATA_I,
  output logic      [31:0]                PRDATA_O,
  output logic                            PREADY_O,
  output logic                            PSLVERR_O,
  // sequencer and float unit
  input  wire exc_entry_pkg::retire_t     RETIRE_I,
  input  wire exc_entry_pkg::fround_t     FROUND_I,
  input  wire logic [31:0]                MSW_I,
  input  wire logic                       XBKPT_REQ_I,
  input  wire logic                       DEVPORT_RST_REQ_I,
  // exception entry results
  output logic                            TAKE_O,
  output logic                            FLUSH_O,
  output logic      [31:0]                VECTOR_O,
  output logic      [31:0]                MSW_NEW_O,
  output logic                            NONRESTART_O,
  output logic                            INEXACT_O
);

  logic [1:0]  ctrl_q;          // [0] masked mode for breakpoints
  logic [31:0] save_pc_q;
  logic [31:0] save_st_q;
  logic        save_st_undef_q;
  logic [31:0] bkpt_addr_q;
  logic [31:0] fstat_q;
  logic [63:0] ftarget_q;
  logic [31:0] fault_addr_q;
  logic [31:0] fault_cause_q;
  logic        nonrestart_q;
  exc_entry_pkg::exc_kind_t kind;
  logic        emul_hit;
  logic        dbk_hit;
  logic        ibk_hit;
  logic        xbk_hit;
  logic        rec;
  logic        masked;
  logic        inexact;
  logic [31:0] base;
  logic        apb_wr;
  logic        apb_rd;

  assign rec    = MSW_I[exc_entry_pkg::MSW_RI_BIT];
  assign masked = ctrl_q[0];
  assign base   = MSW_I[exc_entry_pkg::MSW_VBS_BIT] ? exc_entry_pkg::BASE_HIGH
                                                    : exc_entry_pkg::BASE_LOW;

  // decode of emulation causes
  function automatic logic emul_cause(input exc_entry_pkg::retire_t r, input logic user);
    logic spr_int;
    logic spr_ext;
    spr_int = r.spr_access & r.spr_unimpl & r.spr_internal;
    spr_ext = r.spr_access & r.spr_unimpl & ~r.spr_internal
              & (~r.spr_priv_msb | ~user);
    return r.unimpl | r.cache_seg_tlb | spr_int | spr_ext;
  endfunction : emul_cause

  // cause qualification at the retiring instruction only
  assign emul_hit = RETIRE_I.valid & emul_cause(RETIRE_I, MSW_I[exc_entry_pkg::MSW_USER_BIT]);
  assign dbk_hit  = RETIRE_I.valid & RETIRE_I.dbkpt_match & (~masked | rec);
  assign ibk_hit  = RETIRE_I.valid & RETIRE_I.ibkpt_match & (~masked | rec);
  assign xbk_hit  = RETIRE_I.valid & XBKPT_REQ_I & rec;

  // fixed priority: instruction bkpt, emulation, data bkpt, external
  always_comb begin
    kind = exc_entry_pkg::EXC_NONE;
    if (ibk_hit) begin
      kind = exc_entry_pkg::EXC_IBKPT;
    end else if (emul_hit) begin
      kind = exc_entry_pkg::EXC_EMUL;
    end else if (dbk_hit) begin
      kind = exc_entry_pkg::EXC_DBKPT;
    end else if (xbk_hit) begin
      kind = exc_entry_pkg::EXC_XBKPT;
    end
  end

  // taken only when the instruction retires, younger ones flushed
  assign TAKE_O  = (kind != exc_entry_pkg::EXC_NONE);
  assign FLUSH_O = TAKE_O;

  // vector and new machine state word
  always_comb begin
    case (kind)
      exc_entry_pkg::EXC_EMUL:  VECTOR_O = base | exc_entry_pkg::VEC_EMUL;
      exc_entry_pkg::EXC_DBKPT: VECTOR_O = base | exc_entry_pkg::VEC_DBKPT;
      exc_entry_pkg::EXC_IBKPT: VECTOR_O = base | exc_entry_pkg::VEC_IBKPT;
      exc_entry_pkg::EXC_XBKPT: VECTOR_O = base | exc_entry_pkg::VEC_XBKPT;
      default:                  VECTOR_O = exc_entry_pkg::RST_WORD;
    endcase
    MSW_NEW_O = exc_entry_pkg::RST_WORD;
    MSW_NEW_O[exc_entry_pkg::MSW_VBS_BIT] = MSW_I[exc_entry_pkg::MSW_VBS_BIT];
    MSW_NEW_O[exc_entry_pkg::MSW_ME_BIT]  = MSW_I[exc_entry_pkg::MSW_ME_BIT];
    MSW_NEW_O[exc_entry_pkg::MSW_BO_BIT]  = MSW_I[exc_entry_pkg::MSW_IBO_BIT];
  end

  // inexact detection during rounding
  assign inexact   = FROUND_I.valid & (FROUND_I.differs
                     | (FROUND_I.overflow & ~FROUND_I.ovf_enable));
  assign INEXACT_O = inexact;

  // float status, result class and target register
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fstat_q   <= exc_entry_pkg::RST_WORD;
      ftarget_q <= 64'h0000_0000_0000_0000;
    end else if (inexact) begin
      fstat_q[exc_entry_pkg::FST_STICKY_BIT] <= 1'b1;
      fstat_q[exc_entry_pkg::FST_CLASS_LSB +: 5] <= FROUND_I.class_sign;
      ftarget_q <= FROUND_I.result;
    end else if (apb_wr && PADDR_I == exc_entry_pkg::OFS_FSTAT) begin
      fstat_q <= PWDATA_I;
    end
  end

  // saved pc and saved state on entry
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      save_pc_q <= exc_entry_pkg::RST_WORD;
      save_st_q <= exc_entry_pkg::RST_WORD;
    end else if (TAKE_O) begin
      save_pc_q <= (kind == exc_entry_pkg::EXC_DBKPT)
                   ? RETIRE_I.pc + exc_entry_pkg::INSN_BYTES
                   : RETIRE_I.pc;
      save_st_q <= {16'h0000, MSW_I[15:0]};
    end
  end

  // strap caught after release: saved state flagged as untrustworthy
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      save_st_undef_q <= 1'b0;
    end else if (DEVPORT_RST_REQ_I && !TAKE_O && save_pc_q == exc_entry_pkg::RST_WORD) begin
      save_st_undef_q <= 1'b1;
    end
  end

  // breakpoint address capture; fault registers untouched by it
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bkpt_addr_q <= exc_entry_pkg::RST_WORD;
    end else if (kind == exc_entry_pkg::EXC_DBKPT) begin
      bkpt_addr_q <= RETIRE_I.data_ea;
    end
  end

  // fault registers are software-owned here; no exception in this block writes them
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fault_addr_q  <= exc_entry_pkg::RST_WORD;
      fault_cause_q <= exc_entry_pkg::RST_WORD;
    end else begin
      if (apb_wr && PADDR_I == exc_entry_pkg::OFS_FAULT_A) begin
        fault_addr_q <= PWDATA_I;
      end
      if (apb_wr && PADDR_I == exc_entry_pkg::OFS_FAULT_C) begin
        fault_cause_q <= PWDATA_I;
      end
    end
  end

  // non-restartable latch: set wins over a software clear
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      nonrestart_q <= 1'b0;
    end else if ((kind == exc_entry_pkg::EXC_DBKPT || kind == exc_entry_pkg::EXC_IBKPT)
                 && !masked && !rec) begin
      nonrestart_q <= 1'b1;
    end else if (apb_wr && PADDR_I == exc_entry_pkg::OFS_STATUS && PWDATA_I[0]) begin
      nonrestart_q <= 1'b0;
    end
  end
  assign NONRESTART_O = nonrestart_q;

  // apb slave: zero wait states
  assign apb_wr    = PSEL_I & PENABLE_I & PWRITE_I;
  assign apb_rd    = PSEL_I & ~PWRITE_I;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = 1'b0;

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_q <= exc_entry_pkg::RST_CTRL;
    end else if (apb_wr && PADDR_I == exc_entry_pkg::OFS_CTRL) begin
      ctrl_q <= PWDATA_I[1:0];
    end
  end

  // read data registered in the setup cycle; unmapped reads give zero
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PRDATA_O <= exc_entry_pkg::RST_WORD;
    end else if (apb_rd && !PENABLE_I) begin
      case (PADDR_I)
        exc_entry_pkg::OFS_CTRL:    PRDATA_O <= {30'h0000_0000, ctrl_q};
        exc_entry_pkg::OFS_STATUS:  PRDATA_O <= {30'h0000_0000, save_st_undef_q, nonrestart_q};
        exc_entry_pkg::OFS_SAVE_PC: PRDATA_O <= save_pc_q;
        exc_entry_pkg::OFS_SAVE_ST: PRDATA_O <= save_st_q;
        exc_entry_pkg::OFS_BKPT_AD: PRDATA_O <= bkpt_addr_q;
        exc_entry_pkg::OFS_FSTAT:   PRDATA_O <= fstat_q;
        exc_entry_pkg::OFS_FTARGET: PRDATA_O <= ftarget_q[31:0];
        exc_entry_pkg::OFS_FAULT_A: PRDATA_O <= fault_addr_q;
        exc_entry_pkg::OFS_FAULT_C: PRDATA_O <= fault_cause_q;
        default:                    PRDATA_O <= exc_entry_pkg::RST_WORD;
      endcase
    end
  end

  // checks
  emul_vec_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    kind == exc_entry_pkg::EXC_EMUL |-> VECTOR_O == (base | exc_entry_pkg::VEC_EMUL))
    else $error("emulation vector wrong");
  dbk_pc_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    kind == exc_entry_pkg::EXC_DBKPT |=> save_pc_q == $past(RETIRE_I.pc) + 32'h0000_0004)
    else $error("data breakpoint saved pc wrong");
  save_pc_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    TAKE_O && kind != exc_entry_pkg::EXC_DBKPT |=> save_pc_q == $past(RETIRE_I.pc))
    else $error("saved pc wrong");
  save_st_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    TAKE_O |=> save_st_q[31:16] == 16'h0000 && save_st_q[15:0] == $past(MSW_I[15:0]))
    else $error("saved state wrong");
  xbk_mask_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    !rec |-> kind != exc_entry_pkg::EXC_XBKPT)
    else $error("external breakpoint taken while not recoverable");
  bkpt_cap_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    kind == exc_entry_pkg::EXC_DBKPT |=> bkpt_addr_q == $past(RETIRE_I.data_ea))
    else $error("breakpoint address not captured");
  fault_keep_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    kind == exc_entry_pkg::EXC_DBKPT && !apb_wr |=> $stable(fault_addr_q))
    else $error("fault address changed on data breakpoint");
  inexact_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    inexact |=> fstat_q[exc_entry_pkg::FST_STICKY_BIT] && ftarget_q == $past(FROUND_I.result))
    else $error("inexact actions missing");
  msw_new_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    TAKE_O |-> MSW_NEW_O[exc_entry_pkg::MSW_BO_BIT] == MSW_I[exc_entry_pkg::MSW_IBO_BIT]
               && MSW_NEW_O[exc_entry_pkg::MSW_RI_BIT] == 1'b0)
    else $error("new state word wrong");
  masked_bk_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    masked && !rec |-> !dbk_hit && !ibk_hit)
    else $error("masked breakpoint recognised");

  // vectors for the remaining kinds, and a quiet vector when nothing is taken
  dbk_vec_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    kind == exc_entry_pkg::EXC_DBKPT |-> VECTOR_O == (base | exc_entry_pkg::VEC_DBKPT))
    else $error("data breakpoint vector wrong");

  ibk_vec_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    kind == exc_entry_pkg::EXC_IBKPT |-> VECTOR_O == (base | exc_entry_pkg::VEC_IBKPT))
    else $error("instruction breakpoint vector wrong");

  xbk_vec_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    kind == exc_entry_pkg::EXC_XBKPT |-> VECTOR_O == (base | exc_entry_pkg::VEC_XBKPT))
    else $error("external breakpoint vector wrong");

  idle_vec_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    !TAKE_O |-> VECTOR_O == exc_entry_pkg::RST_WORD)
    else $error("vector driven with no exception");

  // entry happens only at retirement, and always cancels younger work
  flush_take_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    TAKE_O |-> FLUSH_O)
    else $error("exception taken without flush");

  retire_only_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    !RETIRE_I.valid |-> !TAKE_O)
    else $error("exception taken with nothing retiring");

  // priority order: one winner
  ibk_prio_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    ibk_hit |-> kind == exc_entry_pkg::EXC_IBKPT)
    else $error("instruction breakpoint lost priority");

  emul_prio_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    emul_hit && !ibk_hit |-> kind == exc_entry_pkg::EXC_EMUL)
    else $error("emulation lost priority");

  xbk_take_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    xbk_hit && !ibk_hit && !emul_hit && !dbk_hit |-> kind == exc_entry_pkg::EXC_XBKPT)
    else $error("external breakpoint not taken");

  // comparator matches are recognised in unmasked mode
  dbk_hit_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    RETIRE_I.valid && RETIRE_I.dbkpt_match && !masked |-> dbk_hit)
    else $error("data breakpoint match missed");

  ibk_hit_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    RETIRE_I.valid && RETIRE_I.ibkpt_match && !masked |-> ibk_hit)
    else $error("instruction breakpoint match missed");

  // emulation causes
  unimpl_emul_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    RETIRE_I.valid && RETIRE_I.unimpl |-> emul_hit)
    else $error("unimplemented instruction not trapped");

  cache_emul_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    RETIRE_I.valid && RETIRE_I.cache_seg_tlb |-> emul_hit)
    else $error("cache, segment or tlb instruction not trapped");

  spr_int_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    RETIRE_I.valid && RETIRE_I.spr_access && RETIRE_I.spr_unimpl
    && RETIRE_I.spr_internal |-> emul_hit)
    else $error("internal spr access not trapped");

  spr_ext_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    RETIRE_I.valid && RETIRE_I.spr_access && RETIRE_I.spr_unimpl
    && !RETIRE_I.spr_internal && !RETIRE_I.spr_priv_msb |-> emul_hit)
    else $error("external spr access not trapped");

  // inexact detection and its side effects
  inexact_diff_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    FROUND_I.valid && FROUND_I.differs |-> INEXACT_O)
    else $error("inexact missed on differing result");

  inexact_ovf_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    FROUND_I.valid && FROUND_I.overflow && !FROUND_I.ovf_enable |-> INEXACT_O)
    else $error("inexact missed on disabled overflow");

  class_field_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    inexact |=> fstat_q[exc_entry_pkg::FST_CLASS_LSB +: 5] == $past(FROUND_I.class_sign))
    else $error("result class field not updated");

  // state word bits kept, fault cause kept, non-restartable latch set, undefined flag sticky
  msw_keep_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    TAKE_O |-> MSW_NEW_O[exc_entry_pkg::MSW_VBS_BIT] == MSW_I[exc_entry_pkg::MSW_VBS_BIT]
               && MSW_NEW_O[exc_entry_pkg::MSW_ME_BIT] == MSW_I[exc_entry_pkg::MSW_ME_BIT])
    else $error("kept state word bits changed");

  fault_c_keep_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    kind == exc_entry_pkg::EXC_DBKPT && !apb_wr |=> $stable(fault_cause_q))
    else $error("fault cause changed on data breakpoint");

  nr_set_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (kind == exc_entry_pkg::EXC_DBKPT || kind == exc_entry_pkg::EXC_IBKPT) && !rec
    |=> nonrestart_q)
    else $error("non-restartable state not entered");

  undef_keep_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    save_st_undef_q |=> save_st_undef_q)
    else $error("undefined saved state flag lost");

  emul_c: cover property (@(posedge SYS_CLK_I) disable iff (RST_I) kind == exc_entry_pkg::EXC_EMUL);
  dbk_c:  cover property (@(posedge SYS_CLK_I) disable iff (RST_I) kind == exc_entry_pkg::EXC_DBKPT);
  xbk_c:  cover property (@(posedge SYS_CLK_I) disable iff (RST_I) kind == exc_entry_pkg::EXC_XBKPT);
  nr_c:   cover property (@(posedge SYS_CLK_I) disable iff (RST_I) $rose(nonrestart_q));

endmodule : exc_entry
`default_nettype wire

//--- sim/devport_model.sv
`timescale 1ns/1ps
`default_nettype none
module devport_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // trap enables and trap events
  input  wire logic [3:0] trap_en_i,
  input  wire logic [3:0] event_i,
  // request toward the core
  output var  logic       req_o
);
  // registered so the request lags its event by one edge, as a real port would
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_o <= 1'b0;
    end else begin
      req_o <= |(trap_en_i & event_i);
    end
  end
endmodule : devport_model
`default_nettype wire

//--- sim/tb_exc_entry.sv
`timescale 1ns/1ps
`default_nettype none
module tb_exc_entry;
  logic                    clk, rst, psel, pen, pwr, xreq, rreq;
  logic                    pready, pslverr, take, flush, inexact, nrs;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata, vec, mnew, msw, rd;
  logic [3:0]              ten, tev;
  exc_entry_pkg::retire_t  ret, r;
  exc_entry_pkg::fround_t  frd;
  int                      errors, n_tests;

  // core under test and development port partner
  exc_entry exc_entry_i (.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .RETIRE_I(ret), .FROUND_I(frd), .MSW_I(msw),
    .XBKPT_REQ_I(xreq), .DEVPORT_RST_REQ_I(rreq), .TAKE_O(take), .FLUSH_O(flush),
    .VECTOR_O(vec), .MSW_NEW_O(mnew), .NONRESTART_O(nrs), .INEXACT_O(inexact));
  devport_model devport_model_i (.clk_i(clk), .rst_i(rst), .trap_en_i(ten), .event_i(tev),
    .req_o(xreq));

  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic close_out();
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      errors++;
      close_out();
    end
    rd = prdata;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk

  // new state word: base select and check enable kept, byte order from interrupt order
  function automatic logic [31:0] exp_msw(input logic [31:0] m);
    exp_msw = 32'h0000_0000;
    exp_msw[exc_entry_pkg::MSW_VBS_BIT] = m[exc_entry_pkg::MSW_VBS_BIT];
    exp_msw[exc_entry_pkg::MSW_ME_BIT] = m[exc_entry_pkg::MSW_ME_BIT];
    exp_msw[exc_entry_pkg::MSW_BO_BIT] = m[exc_entry_pkg::MSW_IBO_BIT];
  endfunction : exp_msw

  // retire one instruction; outputs are combinational so look mid-cycle
  task automatic exc(input logic [31:0] ev);
    @(posedge clk);
    ret <= r;
    @(negedge clk);
    chk({31'h0, take}, {31'h0, |ev});
    chk({31'h0, flush}, {31'h0, |ev});
    chk(vec, ev);
    if (ev != 0) chk(mnew, exp_msw(msw));
    @(posedge clk);
    ret <= '0;
  endtask : exc

  task automatic fr(input logic d, input logic o, input logic e, input logic exp);
    @(posedge clk);
    frd <= {1'b1, d, o, e, 64'h1234_5678_9ABC_DEF0, 5'h15};
    @(negedge clk);
    chk({31'h0, inexact}, {31'h0, exp});
    @(posedge clk);
    frd <= '0;
  endtask : fr

  initial begin
    errors = 0;
    n_tests = 0;
    {rst, rreq} = 2'b11;
    {psel, pen, pwr, paddr, pwdata, ten, tev} = '0;
    ret = '0;
    r = '0;
    frd = '0;
    msw = 32'h0001_5003;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rreq <= 1'b0;
    // reset values, unmapped write dropped
    apb(1'b1, 8'h24, 32'hFFFF_FFFF);
    rdchk(exc_entry_pkg::OFS_STATUS, 32'h0000_0002);
    for (int i = 0; i < 10; i++) if (i != 1) rdchk(8'(4 * i), 32'h0000_0000);
    chk({31'h0, pslverr}, 32'h0000_0000);
    // emulation causes; external spr with privileged field in user state is not one
    for (int k = 0; k < 5; k++) begin
      r = '0;
      r.valid = 1'b1;
      r.pc = 32'h0000_2000 + 32'(4 * k);
      r.unimpl = (k == 0);
      r.cache_seg_tlb = (k == 1);
      r.spr_access = (k >= 2);
      r.spr_unimpl = (k >= 2);
      r.spr_internal = (k == 2);
      r.spr_priv_msb = (k != 4);
      exc((k == 3) ? 32'h0 : exc_entry_pkg::VEC_EMUL);
      if (k != 3) rdchk(exc_entry_pkg::OFS_SAVE_PC, r.pc);
      if (k != 3) rdchk(exc_entry_pkg::OFS_SAVE_ST, 32'h0000_5003);
    end
    // data breakpoint from high base, fault registers left alone
    apb(1'b1, exc_entry_pkg::OFS_FAULT_A, 32'hA5A5_0001);
    apb(1'b1, exc_entry_pkg::OFS_FAULT_C, 32'h0000_00C3);
    msw <= 32'h0001_5043;
    r = '0;
    r.valid = 1'b1;
    r.pc = 32'h0000_3000;
    r.dbkpt_match = 1'b1;
    r.data_ea = 32'h0000_8888;
    exc(exc_entry_pkg::BASE_HIGH | exc_entry_pkg::VEC_DBKPT);
    rdchk(exc_entry_pkg::OFS_SAVE_PC, 32'h0000_3004);
    rdchk(exc_entry_pkg::OFS_BKPT_AD, 32'h0000_8888);
    rdchk(exc_entry_pkg::OFS_FAULT_A, 32'hA5A5_0001);
    rdchk(exc_entry_pkg::OFS_FAULT_C, 32'h0000_00C3);
    // several causes at once: one winner each time
    r.unimpl = 1'b1;
    exc(exc_entry_pkg::BASE_HIGH | exc_entry_pkg::VEC_EMUL);
    r.ibkpt_match = 1'b1;
    r.pc = 32'h0000_4000;
    exc(exc_entry_pkg::BASE_HIGH | exc_entry_pkg::VEC_IBKPT);
    rdchk(exc_entry_pkg::OFS_SAVE_PC, 32'h0000_4000);
    // masked mode with recoverable flag low hides both breakpoints
    apb(1'b1, exc_entry_pkg::OFS_CTRL, 32'h0000_0001);
    msw <= 32'h0001_5041;
    r.unimpl = 1'b0;
    exc(32'h0000_0000);
    apb(1'b1, exc_entry_pkg::OFS_CTRL, 32'h0000_0000);
    exc(exc_entry_pkg::BASE_HIGH | exc_entry_pkg::VEC_IBKPT);
    apb(1'b0, exc_entry_pkg::OFS_STATUS, 32'h0000_0000);
    chk({31'h0, rd[0]}, 32'h0000_0001);
    chk({31'h0, nrs}, 32'h0000_0001);
    apb(1'b1, exc_entry_pkg::OFS_STATUS, 32'h0000_0001);
    apb(1'b0, exc_entry_pkg::OFS_STATUS, 32'h0000_0000);
    chk({31'h0, rd[0]}, 32'h0000_0000);
    chk({31'h0, nrs}, 32'h0000_0000);
    // external breakpoint waits for the recoverable flag
    ten <= 4'h1;
    tev <= 4'h1;
    r = '0;
    r.valid = 1'b1;
    r.pc = 32'h0000_5000;
    exc(32'h0000_0000);
    msw <= 32'h0001_5043;
    exc(exc_entry_pkg::BASE_HIGH | exc_entry_pkg::VEC_XBKPT);
    rdchk(exc_entry_pkg::OFS_SAVE_PC, 32'h0000_5000);
    tev <= 4'h0;
    // inexact: differs, overflow disabled, overflow enabled and exact
    fr(1'b1, 1'b0, 1'b0, 1'b1);
    rdchk(exc_entry_pkg::OFS_FSTAT, 32'h0201_5000);
    rdchk(exc_entry_pkg::OFS_FTARGET, 32'h9ABC_DEF0);
    fr(1'b0, 1'b1, 1'b0, 1'b1);
    fr(1'b0, 1'b1, 1'b1, 1'b0);
    close_out();
  end
endmodule : tb_exc_entry
`default_nettype wire
